/* File: hdl/bridge_endpoint_irq_signal.sv */
// Design decision made here: the Avalon-MM slave port.
`include "bridge_irq_cfg.svh"
// interrupt status/mask, scratch word and global signal trigger
module bridge_endpoint_irq_signal
  import bridge_irq_pkg::*;
#(
  parameter int MSG_W    = 32,
  parameter int DOORBELL_IRQ_W  = 32,
  parameter int SEV_W    = 32,
  parameter int TEMP_W   = 3,
  parameter int PART_W   = 8,
  parameter int PART_SEL = 0
)(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire addr_t              avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire word_t              avs_writedata,
  output word_t                   avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               downstreamPort,
  input  wire logic [MSG_W-1:0]   messageStatusReg,
  input  wire logic [MSG_W-1:0]   messageStatusMask,
  input  wire logic [DOORBELL_IRQ_W-1:0] inboundDoorbellStatusReg,
  input  wire logic [DOORBELL_IRQ_W-1:0] inboundDoorbellMask,
  input  wire logic [SEV_W-1:0]   switchEventStatusReg,
  input  wire logic [SEV_W-1:0]   switchEventMask,
  input  wire logic               failoverEnable,
  input  wire logic               failoverStartedIn,
  input  wire logic               failoverDoneIn,
  input  wire logic [TEMP_W-1:0]  thermalThresholdStatus,
  input  wire logic [TEMP_W-1:0]  thermalThresholdEnable,
  output logic [PART_W-1:0]       partitionSignalBit,
  output logic                    irqOut
);
  bridge_irq_if wrIf ();

  word_t rdMux;
  word_t busRd;
  logic  busWait;

  avalon_slave u_bus (
    .clk         (clk),
    .reset_n     (reset_n),
    .address     (avs_address),
    .read        (avs_read),
    .write       (avs_write),
    .writedata   (avs_writedata),
    .rdMux       (rdMux),
    .waitrequest (busWait),
    .readdata    (busRd),
    .wr          (wrIf.bus)
  );

  // edge sources: switch events, failover, thermal thresholds
  localparam int EW = SEV_W + 2 + TEMP_W;
  logic [EW-1:0] edgeLvl;
  logic [EW-1:0] edgeRise;
  logic [SEV_W-1:0]  sevRise;
  logic [TEMP_W-1:0] tempRise;
  logic              foStartRise;
  logic              foDoneRise;

  assign edgeLvl = {thermalThresholdStatus, failoverDoneIn,
                    failoverStartedIn, switchEventStatusReg};

  rise_detect #(.W(EW)) u_rise (
    .clk     (clk),
    .reset_n (reset_n),
    .level   (edgeLvl),
    .rise    (edgeRise)
  );

  assign sevRise     = edgeRise[SEV_W-1:0];
  assign foStartRise = edgeRise[SEV_W];
  assign foDoneRise  = edgeRise[SEV_W+1];
  assign tempRise    = edgeRise[EW-1:SEV_W+2];

  function automatic logic hit(input addr_t a, input addr_t ofs);
    hit = wrIf.wrStb && (a == ofs);
  endfunction : hit

  logic wrStatus;
  logic wrMask;
  logic wrScratch;
  logic wrTrigger;
  assign wrStatus  = hit(wrIf.wrAddr, `OFS_IRQ_STATUS);
  assign wrMask    = hit(wrIf.wrAddr, `OFS_IRQ_MASK);
  assign wrScratch = hit(wrIf.wrAddr, `OFS_SCRATCH);
  assign wrTrigger = hit(wrIf.wrAddr, `OFS_GSIG_TRIGGER);

  word_t             mask_q;
  word_t             mask_d;
  word_t             scratch_q;
  word_t             scratch_d;
  logic              sev_q;
  logic              sev_d;
  logic              foStart_q;
  logic              foStart_d;
  logic              foDone_q;
  logic              foDone_d;
  logic              therm_q;
  logic              therm_d;
  logic              msg_q;
  logic              msg_d;
  logic              doorbell_irq_q;
  logic              doorbell_irq_d;
  logic [PART_W-1:0] part_q;
  logic [PART_W-1:0] part_d;
  logic              irq_q;
  logic              irq_d;
  word_t             status;
  word_t             clr;
  logic              sigGen;

  assign clr    = wrStatus ? wrIf.wrData : 32'h00000000;
  assign sigGen = wrTrigger && wrIf.wrData[`GSIG_TRIGGER_BIT];

  // sticky bits: a set in the same cycle as a W1C clear wins
  always_comb
  begin
    mask_d    = mask_q;
    scratch_d = scratch_q;
    if (wrMask)
      mask_d = wrIf.wrData & `IMPL_BITS;
    if (wrScratch)
      scratch_d = wrIf.wrData;
    // summaries follow the source units' unmasked status
    msg_d   = |(messageStatusReg & ~messageStatusMask);
    doorbell_irq_d = |(inboundDoorbellStatusReg & ~inboundDoorbellMask);
    sev_d   = (sev_q & ~clr[`BIT_SWITCH_EVENT_IRQ])
            | (|(sevRise & ~switchEventMask));
    foStart_d = (foStart_q & ~clr[`BIT_FOSTART])
              | (foStartRise & failoverEnable);
    foDone_d  = (foDone_q & ~clr[`BIT_FODONE])
              | (foDoneRise & failoverEnable);
    therm_d = (therm_q & ~clr[`BIT_THERMAL])
            | (|(tempRise & thermalThresholdEnable));
    if (downstreamPort)
    begin
      // downstream ports never hold these upstream-only events
      foStart_d = 1'b0;
      foDone_d  = 1'b0;
      therm_d   = 1'b0;
    end
    part_d = {PART_W{1'b0}};
    if (sigGen)
      part_d[PART_SEL] = 1'b1;
  end

  // visible status word built from the held bits
  always_comb
  begin
    status = 32'h00000000;
    status[`BIT_MSG]     = msg_q;
    status[`BIT_DOORBELL_IRQ]   = doorbell_irq_q;
    status[`BIT_SWITCH_EVENT_IRQ]  = sev_q;
    status[`BIT_FOSTART] = foStart_q;
    status[`BIT_FODONE]  = foDone_q;
    status[`BIT_THERMAL] = therm_q;
  end

  // interrupt from next-cycle status so it tracks the visible bits
  always_comb
  begin
    irq_d = |({therm_d, foDone_d, foStart_d, sev_d, doorbell_irq_d, msg_d}
              & ~{mask_d[`BIT_THERMAL], mask_d[`BIT_FODONE],
                  mask_d[`BIT_FOSTART], mask_d[`BIT_SWITCH_EVENT_IRQ],
                  mask_d[`BIT_DOORBELL_IRQ], mask_d[`BIT_MSG]});
  end

  // read mux; unmapped and reserved read zero
  always_comb
  begin
    case (avs_address)
      `OFS_IRQ_STATUS:   rdMux = status;
      `OFS_IRQ_MASK:     rdMux = mask_q;
      `OFS_SCRATCH:      rdMux = scratch_q;
      `OFS_GSIG_TRIGGER: rdMux = 32'h00000000;
      default:           rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mask_q    <= `MASK_RESET;
      scratch_q <= `SCRATCH_RESET;
      sev_q     <= 1'b0;
      foStart_q <= 1'b0;
      foDone_q  <= 1'b0;
      therm_q   <= 1'b0;
      msg_q     <= 1'b0;
      doorbell_irq_q   <= 1'b0;
      part_q    <= {PART_W{1'b0}};
      irq_q     <= 1'b0;
    end
    else
    begin
      mask_q    <= mask_d;
      scratch_q <= scratch_d;
      sev_q     <= sev_d;
      foStart_q <= foStart_d;
      foDone_q  <= foDone_d;
      therm_q   <= therm_d;
      msg_q     <= msg_d;
      doorbell_irq_q   <= doorbell_irq_d;
      part_q    <= part_d;
      irq_q     <= irq_d;
    end
  end

  assign partitionSignalBit = part_q;
  assign irqOut             = irq_q;
  assign avs_readdata       = busRd;
  assign avs_waitrequest    = busWait;
endmodule : bridge_endpoint_irq_signal

/* File: hdl/bridge_irq_cfg.svh */
// Functional notes
// - thermal alarm sets on enabled threshold rise, W1C
// - downstream ports: thermal alarm reads zero
// - set mask bit keeps its status bit off the interrupt; status still reads it
// - mask bits 0,1,3,4,5,7; others read zero
// - 32-bit read-write scratch word, reset zero
// - global signal bit 0 write signals partition
// - signal sets partition bit in switch status
// - global signal trigger always reads zero
// - message bit follows unmasked message status
// - doorbell bit follows unmasked doorbell status
// - switch event sets on unmasked rise, W1C
// - upstream ports: failover bits set on edge when enabled
`ifndef BRIDGE_IRQ_CFG_SVH
`define BRIDGE_IRQ_CFG_SVH
`define OFS_IRQ_STATUS   12'h404
`define OFS_IRQ_MASK     12'h408
`define OFS_SCRATCH      12'h40C
`define OFS_GSIG_TRIGGER 12'h410
`define BIT_MSG          0
`define BIT_DOORBELL_IRQ        1
`define BIT_SWITCH_EVENT_IRQ       3
`define BIT_FOSTART      4
`define BIT_FODONE       5
`define BIT_THERMAL      7
`define IMPL_BITS        32'h000000BB
`define MASK_RESET       32'h000000BB
`define SCRATCH_RESET    32'h00000000
`define GSIG_TRIGGER_BIT 0
`endif

/* File: hdl/bridge_irq_pkg.sv */
package bridge_irq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_e;
endpackage : bridge_irq_pkg

/* File: hdl/bridge_irq_if.sv */
interface bridge_irq_if;
  import bridge_irq_pkg::*;
  logic  wrStb;
  addr_t wrAddr;
  word_t wrData;
  modport bus (output wrStb, output wrAddr, output wrData);
  modport regs (input wrStb, input wrAddr, input wrData);
endinterface : bridge_irq_if

/* File: hdl/rise_detect.sv */
// one-cycle pulse on each 0-to-1 transition of every bit
module rise_detect
  import bridge_irq_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] last_q;
  logic [W-1:0] last_d;

  // history register; reset to zero so a level high at release counts once
  always_comb
  begin
    last_d = level;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      last_q <= '0;
    else
      last_q <= last_d;
  end

  assign rise = level & ~last_q;
endmodule : rise_detect

/* File: hdl/avalon_slave.sv */
`include "bridge_irq_cfg.svh"
// avalon slave: one wait cycle, then answer; reads mux supplied data
module avalon_slave
  import bridge_irq_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire addr_t address,
  input  wire logic  read,
  input  wire logic  write,
  input  wire word_t writedata,
  input  wire word_t rdMux,
  output logic       waitrequest,
  output word_t      readdata,
  bridge_irq_if.bus  wr
);
  bus_state_e st_q;
  bus_state_e st_d;
  word_t      rd_q;
  word_t      rd_d;
  logic       waitReq_q;
  logic       waitReq_d;
  logic       req;

  assign req = read | write;

  // waitrequest low only in the done cycle, so the master ends there
  always_comb
  begin
    st_d = st_q;
    rd_d = rd_q;
    case (st_q)
      BUS_IDLE:
        if (req)
        begin
          st_d = BUS_DONE;
          rd_d = read ? rdMux : 32'h00000000;
        end
      BUS_DONE:
        st_d = BUS_IDLE;
      default:
        st_d = BUS_IDLE;
    endcase
    // registered so the top port comes straight from a flop
    waitReq_d = (st_d != BUS_DONE);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q      <= BUS_IDLE;
      rd_q      <= 32'h00000000;
      waitReq_q <= 1'b1;
    end
    else
    begin
      st_q      <= st_d;
      rd_q      <= rd_d;
      waitReq_q <= waitReq_d;
    end
  end

  assign waitrequest = waitReq_q;
  assign readdata    = rd_q;
  // write takes effect at the edge where waitrequest is sampled low
  assign wr.wrStb  = write & (st_q == BUS_DONE);
  assign wr.wrAddr = address;
  assign wr.wrData = writedata;
endmodule : avalon_slave

/* File: testbench/bridge_irq_properties.sv */
`include "bridge_irq_cfg.svh"
// bus answer timing, read-back and trigger pulse of the block
module bridge_irq_properties
  import bridge_irq_pkg::*;
#(
  parameter int MSG_W  = 32,
  parameter int PART_W = 8
)(
  input logic              clk,
  input logic              reset_n,
  input addr_t             avs_address,
  input logic              avs_read,
  input logic              avs_write,
  input word_t             avs_writedata,
  input word_t             avs_readdata,
  input logic              avs_waitrequest,
  input logic              downstreamPort,
  input logic [MSG_W-1:0]  messageStatusReg,
  input logic [MSG_W-1:0]  messageStatusMask,
  input logic [PART_W-1:0] partitionSignalBit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic  msgAny;
  logic  wrDone;
  logic  rdDone;
  logic  trigHit;
  word_t scratchQ;
  word_t scratchD;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // accesses complete on the edge that sees waitrequest low
  assign msgAny  = |(messageStatusReg & ~messageStatusMask);
  assign wrDone  = avs_write && !avs_waitrequest;
  assign rdDone  = avs_read && !avs_waitrequest;
  assign trigHit = wrDone && avs_address == `OFS_GSIG_TRIGGER
                   && avs_writedata[`GSIG_TRIGGER_BIT];
  // shadow copy of the scratch word, so read-back needs no bench help
  always_comb
  begin
    scratchD = scratchQ;
    if (wrDone && avs_address == `OFS_SCRATCH)
      scratchD = avs_writedata;
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      scratchQ <= 32'h00000000;
    else
      scratchQ <= scratchD;
  end
  sequence answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence fenced;
    downstreamPort[*3];
  endsequence
  sequence msgHeld;
    msgAny[*3];
  endsequence
  a_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> answer)
    else $error("access not answered after one wait cycle");
  a_trig_pulse: assert property (
    trigHit |=> partitionSignalBit == PART_W'(1))
    else $error("trigger write gave no partition pulse");
  a_trig_cause: assert property (
    partitionSignalBit != '0 |-> $past(trigHit))
    else $error("partition pulse without trigger write");
  a_trig_zero: assert property (
    rdDone && avs_address == `OFS_GSIG_TRIGGER |-> avs_readdata == '0)
    else $error("trigger register read nonzero");
  a_mask_rsvd: assert property (
    rdDone && avs_address == `OFS_IRQ_MASK
    |-> (avs_readdata & ~`IMPL_BITS) == '0)
    else $error("reserved mask bits read nonzero");
  a_fenced_zero: assert property (
    fenced ##0 (rdDone && avs_address == `OFS_IRQ_STATUS)
    |-> avs_readdata[7:4] == 4'h0)
    else $error("downstream port shows failover or thermal bits");
  a_msg_summary: assert property (
    msgHeld ##0 (rdDone && avs_address == `OFS_IRQ_STATUS)
    |-> avs_readdata[0])
    else $error("message summary bit missing");
  a_scratch_back: assert property (
    rdDone && avs_address == `OFS_SCRATCH |-> avs_readdata == scratchQ)
    else $error("scratch word read-back differs");
endmodule : bridge_irq_properties

bind bridge_endpoint_irq_signal bridge_irq_properties #(
  .MSG_W (MSG_W),
  .PART_W(PART_W)
) props (
  .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .downstreamPort, .messageStatusReg,
  .messageStatusMask, .partitionSignalBit
);

/* File: testbench/tb_top.sv */
`include "bridge_irq_cfg.svh"
// register and event checks of the bridge interrupt block
module tb_top
  import bridge_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  addr_t      avs_address = 12'h000;
  logic       avs_read = 1'b0;
  logic       avs_write = 1'b0;
  word_t      avs_writedata = 32'h0;
  word_t      avs_readdata;
  logic       avs_waitrequest;
  logic       downstreamPort = 1'b0;
  word_t      messageStatusReg = 32'h0;
  word_t      messageStatusMask = 32'h0;
  word_t      inboundDoorbellStatusReg = 32'h0;
  word_t      inboundDoorbellMask = 32'h0;
  word_t      switchEventStatusReg = 32'h0;
  word_t      switchEventMask = 32'hFFFFFFFF;
  logic       failoverEnable = 1'b0;
  logic       failoverStartedIn = 1'b0;
  logic       failoverDoneIn = 1'b0;
  logic [2:0] thermalThresholdStatus = 3'h0;
  logic [2:0] thermalThresholdEnable = 3'h0;
  logic [7:0] partitionSignalBit;
  logic       irqOut;
  int         errors = 0;
  int         compares = 0;
  int         pulses = 0;
  word_t      rdVal;
  word_t      evBit[4] = '{32'h08, 32'h10, 32'h20, 32'h80};
  bridge_endpoint_irq_signal uut (
    .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .downstreamPort, .messageStatusReg,
    .messageStatusMask, .inboundDoorbellStatusReg, .inboundDoorbellMask,
    .switchEventStatusReg, .switchEventMask, .failoverEnable,
    .failoverStartedIn, .failoverDoneIn, .thermalThresholdStatus,
    .thermalThresholdEnable, .partitionSignalBit, .irqOut
  );
  always #2.5 clk = ~clk;
  // counts partition pulses seen at clock edges
  always @(posedge clk)
    if (partitionSignalBit !== 8'h00) pulses++;
  task automatic print_verdict;
    begin
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask : print_verdict
  task automatic chk(input word_t got, input word_t exp, input string m);
    begin
      compares++;
      if (got !== exp)
      begin
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
      end
    end
  endtask : chk
  // one access, request held until waitrequest low; bounded wait
  task automatic busOp(input logic wr, input addr_t a, input word_t d);
    int n;
    begin
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
      begin
        chk(32'h1, 32'h0, "bus hang");
        print_verdict();
      end
      rdVal = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask : busOp
  task automatic rdChk(input addr_t a, input word_t exp, input string m);
    begin
      busOp(1'b0, a, 32'h0);
      chk(rdVal, exp, m);
    end
  endtask : rdChk
  // status sources need a couple of cycles to reach the register
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic setSrc(input int k, input logic v);
    case (k)
      0: switchEventStatusReg[2] <= v;
      1: failoverStartedIn <= v;
      2: failoverDoneIn <= v;
      default: thermalThresholdStatus[1] <= v;
    endcase
  endtask : setSrc
  task automatic regTest;
    begin
      rdChk(`OFS_IRQ_MASK, `MASK_RESET, "mask reset");
      rdChk(`OFS_SCRATCH, 32'h0, "scratch reset");
      rdChk(`OFS_IRQ_STATUS, 32'h0, "status reset");
      chk({31'h0, irqOut}, 32'h0, "irq at reset");
      busOp(1'b1, 12'h7FC, 32'hFFFFFFFF);
      rdChk(12'h7FC, 32'h0, "unmapped read");
      busOp(1'b1, `OFS_IRQ_MASK, 32'hFFFFFFFF);
      rdChk(`OFS_IRQ_MASK, `IMPL_BITS, "mask bits");
      busOp(1'b1, `OFS_IRQ_MASK, 32'h0);
      rdChk(`OFS_IRQ_MASK, 32'h0, "mask clear");
      busOp(1'b1, `OFS_SCRATCH, 32'hA5C30F96);
      rdChk(`OFS_SCRATCH, 32'hA5C30F96, "scratch word");
      busOp(1'b1, `OFS_GSIG_TRIGGER, 32'hFFFFFFFE);
      busOp(1'b1, `OFS_GSIG_TRIGGER, 32'h1);
      settle();
      chk(word_t'(pulses), 32'h1, "partition pulses");
      rdChk(`OFS_GSIG_TRIGGER, 32'h0, "trigger read");
    end
  endtask : regTest
  task automatic msgTest;
    begin
      messageStatusReg <= 32'h20;
      settle();
      rdChk(`OFS_IRQ_STATUS, 32'h1, "message bit");
      chk({31'h0, irqOut}, 32'h1, "message irq");
      busOp(1'b1, `OFS_IRQ_MASK, 32'h1);
      chk({31'h0, irqOut}, 32'h0, "masked irq");
      messageStatusMask <= 32'h20;
      busOp(1'b1, `OFS_IRQ_MASK, 32'h0);
      rdChk(`OFS_IRQ_STATUS, 32'h0, "source mask");
      inboundDoorbellStatusReg <= 32'h1;
      settle();
      rdChk(`OFS_IRQ_STATUS, 32'h2, "doorbell bit");
      inboundDoorbellStatusReg <= 32'h0;
      settle();
      chk({31'h0, irqOut}, 32'h0, "irq drop");
    end
  endtask : msgTest
  // blocked rise must not set; enabled rise sets; writing one clears
  task automatic eventTest;
    int k;
    for (k = 0; k < 4; k++)
    begin
      setSrc(k, 1'b1);
      settle();
      rdChk(`OFS_IRQ_STATUS, 32'h0, "blocked event");
      setSrc(k, 1'b0);
      switchEventMask        <= 32'h0;
      failoverEnable         <= 1'b1;
      thermalThresholdEnable <= 3'h2;
      settle();
      setSrc(k, 1'b1);
      settle();
      rdChk(`OFS_IRQ_STATUS, evBit[k], "event set");
      chk({31'h0, irqOut}, 32'h1, "event irq");
      busOp(1'b1, `OFS_IRQ_STATUS, evBit[k]);
      rdChk(`OFS_IRQ_STATUS, 32'h0, "event clear");
      setSrc(k, 1'b0);
      switchEventMask        <= 32'hFFFFFFFF;
      failoverEnable         <= 1'b0;
      thermalThresholdEnable <= 3'h0;
      settle();
    end
  endtask : eventTest
  task automatic fenceTest;
    begin
      downstreamPort         <= 1'b1;
      failoverEnable         <= 1'b1;
      thermalThresholdEnable <= 3'h7;
      settle();
      failoverStartedIn      <= 1'b1;
      thermalThresholdStatus <= 3'h1;
      settle();
      rdChk(`OFS_IRQ_STATUS, 32'h0, "downstream bits");
    end
  endtask : fenceTest
  // watchdog: whole run needs well under 1500 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    regTest();
    msgTest();
    eventTest();
    fenceTest();
    print_verdict();
  end
endmodule : tb_top
